// ===== rtl/dimming_ctrl.sv
// Purpose: Mode detection, PWM chopping and one-wire level programming on one control pin.
// Assumes: The pin is asynchronous; rstn is the power reset of the block.
// Notes: The pin is open drain while acknowledging; the pull-up is outside.
`timescale 1ns/1ns
`default_nettype none
`include "dimming_regs.svh"

module dimming_ctrl #(
    parameter int CNT_W = 16,
    parameter int WINDOW_CYCLES = `DETECT_WINDOW_CYC,
    parameter int SHUTDOWN_CYCLES = `SHUTDOWN_LOW_CYC,
    parameter int ACK_CYCLES = `ACK_LOW_CYC,
    parameter int BIT_TIMEOUT_CYCLES = `BIT_TIMEOUT_CYC,
    parameter logic [7:0] DEV_ADDR = 8'h5a // Arbitrary value; set per product.
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic ctrl_in, // Control pin level, asynchronous.
    output logic ctrl_out, // Control pin drive value, always low.
    output logic ctrl_oe, // High while the block pulls the pin low.
    output logic enabled, // Block is out of shutdown.
    output logic mode_wire, // One-wire dimming is locked in.
    output logic mode_pwm, // PWM dimming is locked in.
    output logic ref_chop, // Gate of the full-scale reference.
    output logic [7:0] ref_mv, // Reference value ahead of the chopper.
    output logic [4:0] level_code, // Stored level code.
    output logic xfer_ok, // One-cycle pulse: a transfer was taken.
    output logic xfer_err // One-cycle pulse: a transfer was discarded.
);

    // Elaboration-time checks on the counts that the counters must hold.
    if (WINDOW_CYCLES <= `DETECT_DELAY_CYC + `DETECT_LOW_CYC || WINDOW_CYCLES >= 2**CNT_W ||
        SHUTDOWN_CYCLES >= 2**CNT_W || ACK_CYCLES < 1 || ACK_CYCLES >= 2**CNT_W ||
        BIT_TIMEOUT_CYCLES < 4 || BIT_TIMEOUT_CYCLES >= 2**(CNT_W - 1)) begin : g_bad_param
        $error("dimming_ctrl: counts do not fit the counters");
    end

    // Counts at counter width.
    localparam logic [CNT_W-1:0] WIN_C = CNT_W'(WINDOW_CYCLES);
    localparam logic [CNT_W-1:0] SHUT_C = CNT_W'(SHUTDOWN_CYCLES);
    localparam logic [CNT_W-1:0] ACK_C = CNT_W'(ACK_CYCLES);
    // Last timer value of the pull, so the pin is held exactly ACK_CYCLES cycles.
    localparam logic [CNT_W-1:0] ACK_LAST_C = CNT_W'(ACK_CYCLES - 1);
    localparam logic [CNT_W-1:0] TMO_C = CNT_W'(BIT_TIMEOUT_CYCLES);
    localparam logic [CNT_W-1:0] DLY_C = CNT_W'(`DETECT_DELAY_CYC);
    localparam logic [CNT_W-1:0] DLOW_C = CNT_W'(`DETECT_LOW_CYC);
    localparam logic [CNT_W-1:0] VAL_C = CNT_W'(`ACK_VALID_CYC);

    // Saturating increment used by all the timers.
    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
        sat_inc = (&v) ? v : v + 1'b1;
    endfunction

    // Pin synchroniser and edge history.
    logic ctrl_meta_r; // First stage, read only by the second.
    logic ctrl_sync_r; // Synchronised pin level.
    logic ctrl_prev_r; // Previous synchronised level.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ctrl_meta_r <= 1'b0;
            ctrl_sync_r <= 1'b0;
            ctrl_prev_r <= 1'b0;
        end else begin
            ctrl_meta_r <= ctrl_in;
            ctrl_sync_r <= ctrl_meta_r;
            ctrl_prev_r <= ctrl_sync_r;
        end
    end

    // Edge strobes of the synchronised pin.
    wire logic rise = ctrl_sync_r & ~ctrl_prev_r;
    wire logic fall = ~ctrl_sync_r & ctrl_prev_r;

    // State and timers.
    dimming_pkg::mode_t mode_r, mode_nxt;
    dimming_pkg::dec_t dec_r, dec_nxt;
    logic [CNT_W-1:0] low_run_r; // Consecutive low cycles, for shutdown.
    logic [CNT_W-1:0] win_r; // Cycles since enable, counted during detection only; zero in the other modes.
    logic [CNT_W-1:0] det_low_r; // Low cycles counted after the detection delay.
    logic [CNT_W-1:0] lo_r; // Low part of the current bit.
    logic [CNT_W-1:0] hi_r; // High part of the current bit.
    logic [CNT_W-1:0] tmr_r; // Acknowledge delay and duration timer.
    logic [15:0] shift_r; // Received bits, first bit at the top.
    logic [4:0] bits_r; // Bits received in this transfer.
    logic bad_r; // A bit with an unclear ratio was seen.
    logic [4:0] level_r; // Stored level code.

    // Shutdown after a long low, from any enabled state.
    wire logic shut = (low_run_r == SHUT_C);

    // One-wire detection: low beyond the detect time inside the window.
    wire logic det_hit = (det_low_r > DLOW_C) && (win_r < WIN_C);
    wire logic win_end = (win_r >= WIN_C);

    // Mode selection; once chosen it holds until shutdown.
    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            dimming_pkg::MODE_OFF: begin
                if (rise) begin
                    mode_nxt = dimming_pkg::MODE_DETECT;
                end
            end
            dimming_pkg::MODE_DETECT: begin
                if (det_hit) begin
                    mode_nxt = dimming_pkg::MODE_WIRE;
                end else if (win_end) begin
                    mode_nxt = dimming_pkg::MODE_PWM;
                end
            end
            dimming_pkg::MODE_PWM, dimming_pkg::MODE_WIRE: begin
                mode_nxt = mode_r;
            end
            default: begin
                mode_nxt = dimming_pkg::MODE_OFF;
            end
        endcase
        if (shut) begin
            mode_nxt = dimming_pkg::MODE_OFF;
        end
    end

    // Bit decision at the falling edge that closes a bit.
    wire logic [CNT_W:0] lo2 = {lo_r, 1'b0};
    wire logic [CNT_W:0] hi2 = {hi_r, 1'b0};
    wire logic bit_one = ({1'b0, hi_r} >= lo2);
    wire logic bit_zero = ({1'b0, lo_r} >= hi2);
    wire logic [15:0] word = {shift_r[14:0], bit_one};
    wire logic [4:0] bits_inc = bits_r + 5'h01;
    wire logic bit_timeout = (lo_r >= TMO_C) || (hi_r >= TMO_C);

    // Transfer check on the sixteenth bit.
    wire logic bad_now = bad_r | ~(bit_one | bit_zero);
    wire logic last_bit = (dec_r == dimming_pkg::DEC_BIT) && fall && (bits_inc == `XFER_BITS);
    wire logic xfer_good = (word[15:8] == DEV_ADDR) && !word[`SUB_ADDR_HI_BIT] &&
        !word[`SUB_ADDR_LO_BIT] && !bad_now;
    wire logic take = last_bit && xfer_good;
    wire logic ack_req = take && word[`ACK_FLAG_BIT];
    wire logic drop = (last_bit && !xfer_good) ||
        ((dec_r == dimming_pkg::DEC_BIT) && bit_timeout && bits_r != 5'h00);

    // Bit decoder and acknowledge sequencer, live only in one-wire mode.
    always_comb begin
        dec_nxt = dec_r;
        case (dec_r)
            dimming_pkg::DEC_IDLE: begin
                if (ctrl_sync_r) begin
                    dec_nxt = dimming_pkg::DEC_READY; // Start condition seen.
                end
            end
            dimming_pkg::DEC_READY: begin
                if (fall) begin
                    dec_nxt = dimming_pkg::DEC_BIT;
                end
            end
            dimming_pkg::DEC_BIT: begin
                if (last_bit) begin
                    dec_nxt = ack_req ? dimming_pkg::DEC_ACKWAIT : dimming_pkg::DEC_IDLE;
                end else if (fall && bits_inc == `BYTE_BITS) begin
                    dec_nxt = dimming_pkg::DEC_IDLE; // End of stream closed the byte.
                end else if (bit_timeout) begin
                    dec_nxt = dimming_pkg::DEC_IDLE;
                end
            end
            dimming_pkg::DEC_ACKWAIT: begin
                if (tmr_r >= VAL_C) begin
                    dec_nxt = dimming_pkg::DEC_ACK;
                end
            end
            dimming_pkg::DEC_ACK: begin
                if (tmr_r >= ACK_LAST_C) begin
                    dec_nxt = dimming_pkg::DEC_IDLE;
                end
            end
            default: begin
                dec_nxt = dimming_pkg::DEC_IDLE;
            end
        endcase
        if (mode_r != dimming_pkg::MODE_WIRE && mode_nxt != dimming_pkg::MODE_WIRE) begin
            dec_nxt = dimming_pkg::DEC_IDLE;
        end
        if (shut) begin
            dec_nxt = dimming_pkg::DEC_IDLE;
        end
    end

    // State registers.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            mode_r <= dimming_pkg::MODE_OFF;
            dec_r <= dimming_pkg::DEC_IDLE;
        end else begin
            mode_r <= mode_nxt;
            dec_r <= dec_nxt;
        end
    end

    // Shutdown and detection timers.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            low_run_r <= '0;
            win_r <= '0;
            det_low_r <= '0;
        end else begin
            low_run_r <= ctrl_sync_r ? '0 : sat_inc(low_run_r);
            win_r <= (mode_r == dimming_pkg::MODE_DETECT) ? sat_inc(win_r) : '0;
            det_low_r <= (mode_r == dimming_pkg::MODE_DETECT && !ctrl_sync_r && win_r >= DLY_C)
                ? sat_inc(det_low_r) : '0;
        end
    end

    // Bit half timers, restarted by every falling edge.
    wire logic in_bit = (dec_r == dimming_pkg::DEC_BIT) && !fall;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            lo_r <= '0;
            hi_r <= '0;
        end else begin
            lo_r <= (in_bit && !ctrl_sync_r) ? sat_inc(lo_r) : (in_bit ? lo_r : '0);
            hi_r <= (in_bit && ctrl_sync_r) ? sat_inc(hi_r) : (in_bit ? hi_r : '0);
        end
    end

    // Received bits and transfer bookkeeping.
    wire logic bit_done = (dec_r == dimming_pkg::DEC_BIT) && fall;
    wire logic xfer_clear = drop || last_bit || (dec_r != dimming_pkg::DEC_BIT &&
        bits_r == 5'h00) || mode_r != dimming_pkg::MODE_WIRE;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            shift_r <= 16'h0000;
            bits_r <= 5'h00;
            bad_r <= 1'b0;
        end else if (xfer_clear) begin
            shift_r <= 16'h0000;
            bits_r <= 5'h00;
            bad_r <= 1'b0;
        end else if (bit_done) begin
            shift_r <= word;
            bits_r <= bits_inc;
            bad_r <= bad_now;
        end
    end

    // Acknowledge timer counts within the wait and pull phases.
    wire logic ack_phase = (dec_r == dimming_pkg::DEC_ACKWAIT) || (dec_r == dimming_pkg::DEC_ACK);
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            tmr_r <= '0;
        end else if (ack_phase && dec_nxt == dec_r) begin
            tmr_r <= sat_inc(tmr_r);
        end else begin
            tmr_r <= '0;
        end
    end

    // Stored level: only a good transfer or power reset changes it.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            level_r <= `LEVEL_RESET;
        end else if (take) begin
            level_r <= word[4:0];
        end
    end

    // Registered pin and status outputs.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ctrl_out <= 1'b0;
            ctrl_oe <= 1'b0;
            enabled <= 1'b0;
            mode_wire <= 1'b0;
            mode_pwm <= 1'b0;
            ref_chop <= 1'b0;
            level_code <= `LEVEL_RESET;
            xfer_ok <= 1'b0;
            xfer_err <= 1'b0;
        end else begin
            ctrl_out <= 1'b0;
            ctrl_oe <= (dec_nxt == dimming_pkg::DEC_ACK);
            enabled <= (mode_nxt != dimming_pkg::MODE_OFF);
            mode_wire <= (mode_nxt == dimming_pkg::MODE_WIRE);
            mode_pwm <= (mode_nxt == dimming_pkg::MODE_PWM);
            // PWM and detection follow the pin; one-wire holds the reference on.
            ref_chop <= (mode_nxt == dimming_pkg::MODE_WIRE) ||
                ((mode_nxt != dimming_pkg::MODE_OFF) && ctrl_sync_r);
            level_code <= take ? word[4:0] : level_r;
            xfer_ok <= take;
            xfer_err <= drop;
        end
    end

    // Reference value: full scale outside one-wire mode, else the stored level.
    level_ref_table u_table (
        .clock(clock),
        .rstn(rstn),
        .code(level_r),
        .full_scale(mode_r != dimming_pkg::MODE_WIRE),
        .mv_r(ref_mv)
    );

endmodule // dimming_ctrl
`default_nettype wire

// ===== rtl/dimming_regs.svh
// Purpose: Timing counts and fixed values for the single-pin dimming control front end.
// Assumes: A 10 MHz core clock; times are kept in microseconds.
// Notes: Cycle counts are derived from the times, so changing the clock rate moves them all.
`ifndef DIMMING_REGS_SVH
`define DIMMING_REGS_SVH

// Core clock rate in MHz, which is cycles per microsecond.
`define CLK_MHZ 10

// Delay after enable before a low level counts toward one-wire detection.
`define DETECT_DELAY_US 100
`define DETECT_DELAY_CYC (`DETECT_DELAY_US * `CLK_MHZ)
// Low time that must be exceeded to select one-wire mode.
`define DETECT_LOW_US 260
`define DETECT_LOW_CYC (`DETECT_LOW_US * `CLK_MHZ)
// Detection window measured from the enabling rising edge.
`define DETECT_WINDOW_US 1000
`define DETECT_WINDOW_CYC (`DETECT_WINDOW_US * `CLK_MHZ)
// Continuous low time that shuts the block down.
`define SHUTDOWN_LOW_US 2500
`define SHUTDOWN_LOW_CYC (`SHUTDOWN_LOW_US * `CLK_MHZ)
// Longest acknowledge pull-down.
`define ACK_LOW_US 512
`define ACK_LOW_CYC (`ACK_LOW_US * `CLK_MHZ)
// Delay from the closing falling edge to the acknowledge pull-down.
`define ACK_VALID_US 2
`define ACK_VALID_CYC (`ACK_VALID_US * `CLK_MHZ)
// A bit half longer than this abandons the transfer in progress.
`define BIT_TIMEOUT_US 600
`define BIT_TIMEOUT_CYC (`BIT_TIMEOUT_US * `CLK_MHZ)

// Level code after power reset, which is full scale.
`define LEVEL_RESET 5'h1f
// Full-scale reference in millivolts.
`define FULL_SCALE_MV 8'hc8
// Data byte field positions.
`define ACK_FLAG_BIT 7
`define SUB_ADDR_HI_BIT 6
`define SUB_ADDR_LO_BIT 5
// Bits per byte and per transfer.
`define BYTE_BITS 5'h08
`define XFER_BITS 5'h10

`endif

// ===== rtl/dimming_pkg.sv
// Purpose: Types shared by the dimming control front end.
// Assumes: Used with package-qualified names only.
// Notes: State codes are one-hot.
package dimming_pkg;

    // Operating mode of the block.
    typedef enum logic [3:0] {
        MODE_OFF    = 4'h1,
        MODE_DETECT = 4'h2,
        MODE_PWM    = 4'h4,
        MODE_WIRE   = 4'h8
    } mode_t;

    // Bit decoder and acknowledge sequencer states.
    typedef enum logic [4:0] {
        DEC_IDLE    = 5'h01,
        DEC_READY   = 5'h02,
        DEC_BIT     = 5'h04,
        DEC_ACKWAIT = 5'h08,
        DEC_ACK     = 5'h10
    } dec_t;

endpackage

// ===== rtl/level_ref_table.sv
// Purpose: Turns the stored level code into a reference value in millivolts.
// Assumes: Code and select come from logic on the same clock.
// Notes: The result is registered, so it follows its inputs by one cycle.
`timescale 1ns/1ns
`default_nettype none
`include "dimming_regs.svh"

module level_ref_table #(
    parameter logic [7:0] LOW_BASE_MV = 8'h05,
    parameter logic [7:0] LOW_STEP_MV = 8'h03
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [4:0] code,
    input wire logic full_scale,
    output logic [7:0] mv_r
);

    // Maps a level code onto its reference value.
    function automatic logic [7:0] code_to_mv(input logic [4:0] c);
        logic [7:0] c8;
        c8 = {3'h0, c};
        if (c8 >= 8'h18) begin
            code_to_mv = 8'h74 + 8'((c8 - 8'h18) * 8'h0c);
        end else if (c8 >= 8'h0d) begin
            code_to_mv = 8'h2c + 8'((c8 - 8'h0d) * 8'h06);
        end else begin
            code_to_mv = LOW_BASE_MV + 8'(c8 * LOW_STEP_MV);
        end
    endfunction

    // Selected value before the output register.
    wire logic [7:0] mv_nxt = full_scale ? `FULL_SCALE_MV : code_to_mv(code);

    // Output register, full scale after reset.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            mv_r <= `FULL_SCALE_MV;
        end else begin
            mv_r <= mv_nxt;
        end
    end

endmodule // level_ref_table
`default_nettype wire

// ===== verif/dimming_ctrl_props.sv
// Purpose: Port-level checks of the dimming control front end.
// Assumes: One clock domain; rstn is the power reset.
// Notes: Helper counters time the acknowledge pull.
`timescale 1ns/1ns
`default_nettype none
module dimming_ctrl_props #(
    parameter int ACK_CYCLES = 5120
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic ctrl_out,
    input wire logic ctrl_oe,
    input wire logic enabled,
    input wire logic mode_wire,
    input wire logic mode_pwm,
    input wire logic ref_chop,
    input wire logic [7:0] ref_mv,
    input wire logic [4:0] level_code,
    input wire logic xfer_ok,
    input wire logic xfer_err
);
    logic [15:0] oe_cnt_r; // Length of the current pull-down.
    logic [5:0] since_ok_r; // Cycles since the last good transfer.
    // Counts pull-down cycles, and cycles since a taken transfer.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            oe_cnt_r <= 16'h0000;
            since_ok_r <= 6'h3f;
        end else begin
            oe_cnt_r <= ctrl_oe ? oe_cnt_r + 16'h0001 : 16'h0000;
            since_ok_r <= xfer_ok ? 6'h00 : since_ok_r + {5'h00, since_ok_r != 6'h3f};
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    oe_low_a: assert property (ctrl_oe |-> !ctrl_out)
        else $error("pin driven high");
    ack_mode_a: assert property (ctrl_oe |-> mode_wire)
        else $error("pull outside wire mode");
    ack_cause_a: assert property ($rose(ctrl_oe) |-> since_ok_r <= 6'd24)
        else $error("pull without a taken transfer");
    ack_cap_a: assert property (oe_cnt_r <= ACK_CYCLES)
        else $error("pull too long");
    ack_len_a: assert property ($fell(ctrl_oe) |-> oe_cnt_r >= ACK_CYCLES)
        else $error("pull too short");
    mode_hold_a: assert property (mode_wire |=> mode_wire || !enabled)
        else $error("wire mode lost");
    modes_excl_a: assert property (!(mode_wire && mode_pwm))
        else $error("two modes");
    off_quiet_a: assert property (!enabled |-> !mode_wire && !mode_pwm && !ctrl_oe)
        else $error("active while off");
    pwm_ref_a: assert property (mode_pwm |-> ref_mv == 8'hc8)
        else $error("pwm reference not full");
    wire_chop_a: assert property (mode_wire && $past(mode_wire) |-> ref_chop)
        else $error("chopper off in wire mode");
    level_kept_a: assert property (!xfer_ok |-> $stable(level_code))
        else $error("level moved");
    err_keep_a: assert property (xfer_err |-> !xfer_ok && $stable(level_code))
        else $error("bad transfer taken");
endmodule // dimming_ctrl_props
bind dimming_ctrl dimming_ctrl_props #(.ACK_CYCLES(ACK_CYCLES)) u_props (.clock(clock),
    .rstn(rstn), .ctrl_out(ctrl_out), .ctrl_oe(ctrl_oe), .enabled(enabled),
    .mode_wire(mode_wire), .mode_pwm(mode_pwm), .ref_chop(ref_chop), .ref_mv(ref_mv),
    .level_code(level_code), .xfer_ok(xfer_ok), .xfer_err(xfer_err));
`default_nettype wire

// ===== verif/host_link.sv
// Purpose: Host model driving the control pin open drain.
// Assumes: External pull-up; levels change 1 ns after a clock edge.
// Notes: Bit halves are counted in core clock cycles.
`timescale 1ns/1ns
`default_nettype none
module host_link (
    input wire logic clock,
    input wire logic ctrl_oe,
    input wire logic ctrl_out,
    output logic pin
);
    logic pull_low = 1'b0; // Host pull-down; released means high.
    // Wire level: either party may pull low, the pull-up wins otherwise.
    assign pin = !(pull_low || (ctrl_oe && !ctrl_out));
    // Holds one level for a count of cycles.
    task automatic put(input logic low, input int cyc);
        pull_low = low;
        repeat (cyc) @(posedge clock);
        #1;
    endtask
    // One byte, MSB first, ratio 3 to 1, then end of stream and start.
    task automatic send_byte(input logic [7:0] b, input int u);
        for (int i = 7; i >= 0; i--) begin
            put(1'b1, b[i] ? u : 3 * u);
            put(1'b0, b[i] ? 3 * u : u);
        end
        put(1'b1, 50);
        put(1'b0, 50);
    endtask
    // Address byte then data byte.
    task automatic send_xfer(input logic [7:0] a, input logic [7:0] d, input int u);
        put(1'b0, 50);
        send_byte(a, u);
        send_byte(d, u);
    endtask
endmodule // host_link
`default_nettype wire

// ===== verif/one_wire_dimming_control_bench.sv
// Purpose: Self-checking bench for the dimming control front end.
// Assumes: Shortened counts; 100 ns clock.
// Notes: Random codes come from an LFSR seeded with a fixed value.
`timescale 1ns/1ns
`default_nettype none
module one_wire_dimming_control_bench;
    localparam logic [7:0] ADDR = 8'h5a; // Arbitrary device address.
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic pin, ctrl_out, ctrl_oe, enabled, mode_wire, mode_pwm, ref_chop, xfer_ok, xfer_err;
    logic [7:0] ref_mv;
    logic [4:0] level_code, code, last;
    logic [31:0] seed = 32'h0000a27b;
    logic flag;
    int bad_count = 0;
    int checks = 0;
    int h;
    int ok_cnt = 0; // Taken-transfer pulses seen on the design's output.
    int err_cnt = 0; // Discarded-transfer pulses seen on the design's output.
    dimming_ctrl #(.WINDOW_CYCLES(4000), .SHUTDOWN_CYCLES(5000), .ACK_CYCLES(200),
        .BIT_TIMEOUT_CYCLES(500), .DEV_ADDR(ADDR)) u_dut (.clock(clock), .rstn(rstn),
        .ctrl_in(pin), .ctrl_out(ctrl_out), .ctrl_oe(ctrl_oe), .enabled(enabled),
        .mode_wire(mode_wire), .mode_pwm(mode_pwm), .ref_chop(ref_chop), .ref_mv(ref_mv),
        .level_code(level_code), .xfer_ok(xfer_ok), .xfer_err(xfer_err));
    host_link u_host (.clock(clock), .ctrl_oe(ctrl_oe), .ctrl_out(ctrl_out), .pin(pin));
    // Counts the one-cycle outcome pulses of the design.
    always @(posedge clock) begin
        ok_cnt <= ok_cnt + int'(xfer_ok === 1'b1);
        err_cnt <= err_cnt + int'(xfer_err === 1'b1);
    end
    // Clock of 100 ns period.
    initial begin
        forever #50 clock = ~clock;
    end
    // Next LFSR state.
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Expected reference for a level code.
    function automatic logic [7:0] exp_mv(input logic [4:0] c);
        if (c >= 5'd24) return 8'd116 + 8'd12 * ({3'h0, c} - 8'd24);
        if (c >= 5'd13) return 8'd44 + 8'd6 * ({3'h0, c} - 8'd13);
        return 8'h05 + 8'h03 * {3'h0, c};
    endfunction
    // Counts a comparison and reports a miss.
    task automatic check(input logic ok, input string msg);
        checks++;
        if (!ok) begin
            bad_count++;
            $display("Error %0t %s", $time, msg);
        end
    endtask
    // Prints the counts and the verdict.
    task automatic stop_test();
        $display("checks %0d errors %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // One transfer with ack and level checks; good is whether it should be taken.
    task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic good);
        int ok0;
        int err0;
        ok0 = ok_cnt;
        err0 = err_cnt;
        seed = lfsr(seed);
        u_host.send_xfer(a, d, 20 + int'(seed[4:0]) % 21);
        check(pin === !(good && d[7]), "ack level");
        check(ok_cnt == ok0 + int'(good) && err_cnt == err0 + int'(!good), "outcome");
        u_host.put(1'b0, 300);
        if (good) last = d[4:0];
        check(level_code === last, "level");
        check(ref_mv === exp_mv(last), "reference");
    endtask
    // Main sequence.
    initial begin
        repeat (12) @(posedge clock);
        #1;
        check(level_code === 5'h1f && ref_mv === 8'hc8 && ctrl_oe === 1'b0, "reset");
        rstn = 1'b1;
        u_host.put(1'b0, 100);
        // PWM at 20 kHz with random duty.
        for (int i = 0; i < 40; i++) begin
            seed = lfsr(seed);
            h = 50 + int'(seed[8:0]) % 401;
            u_host.put(1'b0, h);
            check(ref_chop === 1'b1, "chop high");
            u_host.put(1'b1, 500 - h);
            check(ref_chop === 1'b0, "chop low");
        end
        u_host.put(1'b0, 100);
        check(mode_pwm === 1'b1 && mode_wire === 1'b0, "pwm mode");
        check(ref_chop === 1'b1 && ref_mv === 8'hc8, "full reference");
        u_host.put(1'b1, 3000);
        u_host.put(1'b0, 100);
        check(mode_pwm === 1'b1 && mode_wire === 1'b0, "mode kept");
        u_host.put(1'b1, 5200);
        check(enabled === 1'b0 && mode_pwm === 1'b0, "shutdown");
        u_host.put(1'b0, 1100);
        u_host.put(1'b1, 2750);
        check(mode_wire === 1'b1, "wire mode");
        u_host.put(1'b0, 200);
        last = 5'h1f;
        // Corner codes, then random codes and flags.
        for (int i = 0; i < 11; i++) begin
            seed = lfsr(seed);
            code = (i < 5) ? 5'(32'h1f180d17 >> (8 * i)) : seed[4:0];
            flag = (i < 5) ? i[0] : seed[9];
            xfer(ADDR, {flag, 2'b00, code}, 1'b1);
        end
        xfer(ADDR ^ 8'h01, 8'h84, 1'b0);
        xfer(ADDR, 8'ha3, 1'b0);
        // Stalled transfer: one bit, then a low longer than the bit timeout.
        h = err_cnt;
        u_host.put(1'b1, 30);
        u_host.put(1'b0, 90);
        u_host.put(1'b1, 600);
        u_host.put(1'b0, 300);
        check(err_cnt == h + 1 && level_code === last, "stalled transfer");
        u_host.put(1'b1, 5200);
        u_host.put(1'b0, 4200);
        check(mode_pwm === 1'b1 && level_code === last, "level after restart");
        rstn = 1'b0;
        #1;
        check(level_code === 5'h1f, "power reset");
        stop_test();
    end
    // Cuts a hang short.
    initial begin
        repeat (95000) @(posedge clock);
        bad_count++;
        stop_test();
    end
endmodule // one_wire_dimming_control_bench
`default_nettype wire
